// [logic/ccr_pkg.sv]
package ccr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CCR_OFS_CONTROL = 8'h01;
	localparam logic [7:0] CCR_OFS_IDENT = 8'h03;
	localparam logic [7:0] CCR_OFS_CHARGE = 8'h04;
	localparam logic [7:0] CCR_UNMAPPED_DATA = 8'hff;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CCR_RESET_CMD_BIT = 7;
	localparam int CCR_FAST_LSB = 4;
	localparam int CCR_TERM_LSB = 0;
	localparam int CCR_TE_BIT = 3;
	localparam logic [7:0] CCR_CHARGE_RST = 8'h89;
	localparam logic [7:0] CCR_CONTROL_RST = 8'h30;
	localparam logic [7:0] CCR_CONTROL_WMASK = 8'hff;
	// Arbitrary identification bits
	localparam logic [4:0] CCR_ID_UPPER = 5'h15;

	// ------------------------------------------------------------
	// Sense voltages in microvolts, clamp current in microamps
	// ------------------------------------------------------------
	localparam int CCR_FAST_BASE_UV = 37400;
	localparam int CCR_FAST_STEP_UV = 6800;
	localparam int CCR_TERM_BASE_UV = 3400;
	localparam int CCR_TERM_STEP_UV = 3400;
	localparam int CCR_SHORT_LIMIT_UA = 10000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CCR_CLK_HZ = 50000000;
	localparam int CCR_SAFETY_S = 1800;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccr_req_t;

	typedef struct packed {
		logic below_short;
		logic below_refresh;
		logic full;
		logic current_low;
	} ccr_sense_t;

	typedef enum logic [1:0] {
		CCR_ST_IDLE = 2'b00,
		CCR_ST_CHARGE = 2'b01,
		CCR_ST_DONE = 2'b10,
		CCR_ST_FAULT = 2'b11
	} ccr_state_t;

	function automatic logic [16:0] ccr_uv(input logic [2:0] code,
		input int base, input int step);
		int v;
		v = base + int'(code) * step;
		return v[16:0];
	endfunction : ccr_uv

endpackage : ccr_pkg

// [logic/ccr_safety_timer.sv]
`timescale 1ns/1ps
module ccr_safety_timer
	import ccr_pkg::*;
#(
	parameter int LIMIT = 32'd90000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic run,
	input wire logic clear,
	output logic expired
);
	initial begin
		if (LIMIT < 2) begin
			$error("LIMIT too small");
		end
	end

	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic exp_reg;
	logic exp_next;

	// ------------------------------------------------------------
	// Count while charging
	// ------------------------------------------------------------
	always_comb begin
		cnt_next = cnt_reg;
		exp_next = exp_reg;
		if (clear) begin
			cnt_next = '0;
			exp_next = 1'b0;
		end else if (run && !exp_reg) begin
			cnt_next = cnt_reg + 32'd1;
			if (cnt_reg == 32'(LIMIT - 1)) begin
				exp_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
endmodule : ccr_safety_timer

// [logic/ccr_charge_fsm.sv]
`timescale 1ns/1ps
module ccr_charge_fsm
	import ccr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic charger_reset,
	input wire logic term_en,
	input wire logic timer_expired,
	input ccr_sense_t sense,
	output ccr_state_t state
);
	ccr_state_t st_reg;
	ccr_state_t st_next;

	// ------------------------------------------------------------
	// Charge sequence
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			CCR_ST_IDLE: begin
				st_next = CCR_ST_CHARGE;
			end
			CCR_ST_CHARGE: begin
				if (timer_expired) begin
					st_next = CCR_ST_FAULT;
				end else if (term_en && sense.full && sense.current_low) begin
					st_next = CCR_ST_DONE;
				end
			end
			CCR_ST_DONE: begin
				if (sense.below_refresh) begin
					st_next = CCR_ST_CHARGE;
				end
			end
			default: begin
				st_next = CCR_ST_FAULT;
			end
		endcase
		if (charger_reset) begin
			st_next = CCR_ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= CCR_ST_IDLE;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign state = st_reg;
endmodule : ccr_charge_fsm

// [logic/ccr_regs.sv]
`timescale 1ns/1ps
module ccr_regs
	import ccr_pkg::*;
#(
	parameter logic [2:0] REVISION = 3'h5,
	parameter int SAFETY_CYCLES = 90000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input ccr_req_t req,
	input ccr_sense_t sense,
	output logic [7:0] rdata,
	output logic charger_reset,
	output logic converter_on,
	output logic short_clamp,
	output logic [16:0] reg_sense_uv,
	output logic [16:0] term_sense_uv,
	output logic [15:0] clamp_ua,
	output logic battery_fault,
	output logic [1:0] charge_status
);
	// Revision value is arbitrary
	initial begin
		if (SAFETY_CYCLES < 2) begin
			$error("SAFETY_CYCLES too small");
		end
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [6:0] chg_reg;
	logic [6:0] chg_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rst_cmd_reg;
	logic rst_cmd_next;
	logic conv_reg;
	logic conv_next;
	logic clamp_reg;
	logic clamp_next;
	logic fault_reg;
	logic fault_next;
	logic [1:0] stat_reg;
	logic [1:0] stat_next;
	logic [16:0] vreg_reg;
	logic [16:0] vreg_next;
	logic [16:0] vterm_reg;
	logic [16:0] vterm_next;
	logic [15:0] ilim_reg;
	logic [15:0] ilim_next;
	logic timer_expired;
	ccr_state_t state;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		chg_next = chg_reg;
		rst_cmd_next = 1'b0;
		if (req.wr) begin
			if (req.addr == CCR_OFS_CONTROL) begin
				ctrl_next = req.wdata & CCR_CONTROL_WMASK;
			end else if (req.addr == CCR_OFS_CHARGE) begin
				chg_next = req.wdata[6:0];
				rst_cmd_next = req.wdata[CCR_RESET_CMD_BIT];
			end else if (req.addr == CCR_OFS_IDENT) begin
				ctrl_next = ctrl_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rdata_next = rdata_reg;
		if (req.rd) begin
			if (req.addr == CCR_OFS_CONTROL) begin
				rdata_next = ctrl_reg;
			end else if (req.addr == CCR_OFS_IDENT) begin
				rdata_next = {CCR_ID_UPPER, REVISION};
			end else if (req.addr == CCR_OFS_CHARGE) begin
				rdata_next = {1'b1, chg_reg};
			end else begin
				rdata_next = CCR_UNMAPPED_DATA;
			end
		end
	end

	// ------------------------------------------------------------
	// Charger outputs
	// ------------------------------------------------------------
	always_comb begin
		vreg_next = ccr_uv(chg_reg[CCR_FAST_LSB +: 3],
			CCR_FAST_BASE_UV, CCR_FAST_STEP_UV);
		vterm_next = ccr_uv(chg_reg[CCR_TERM_LSB +: 3],
			CCR_TERM_BASE_UV, CCR_TERM_STEP_UV);
		clamp_next = sense.below_short;
		ilim_next = 16'(CCR_SHORT_LIMIT_UA);
		conv_next = (state == CCR_ST_CHARGE);
		fault_next = (state == CCR_ST_FAULT);
		stat_next = state;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CCR_CONTROL_RST;
			chg_reg <= CCR_CHARGE_RST[6:0];
			rdata_reg <= '0;
			rst_cmd_reg <= 1'b0;
			conv_reg <= 1'b0;
			clamp_reg <= 1'b0;
			fault_reg <= 1'b0;
			stat_reg <= '0;
			vreg_reg <= '0;
			vterm_reg <= '0;
			ilim_reg <= '0;
		end else if (clk_en) begin
			ctrl_reg <= ctrl_next;
			chg_reg <= chg_next;
			rdata_reg <= rdata_next;
			rst_cmd_reg <= rst_cmd_next;
			conv_reg <= conv_next;
			clamp_reg <= clamp_next;
			fault_reg <= fault_next;
			stat_reg <= stat_next;
			vreg_reg <= vreg_next;
			vterm_reg <= vterm_next;
			ilim_reg <= ilim_next;
		end
	end

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	// timer runs only in CCR_ST_CHARGE, cleared in CCR_ST_IDLE or on reset command
	ccr_safety_timer #(
		.LIMIT(SAFETY_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(state == CCR_ST_CHARGE),
		.clear(rst_cmd_reg || state == CCR_ST_IDLE),
		.expired(timer_expired)
	);

	ccr_charge_fsm u_fsm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.charger_reset(rst_cmd_reg),
		.term_en(ctrl_reg[CCR_TE_BIT]),
		.timer_expired(timer_expired),
		.sense(sense),
		.state(state)
	);

	assign rdata = rdata_reg;
	assign charger_reset = rst_cmd_reg;
	assign converter_on = conv_reg;
	assign short_clamp = clamp_reg;
	assign reg_sense_uv = vreg_reg;
	assign term_sense_uv = vterm_reg;
	assign clamp_ua = ilim_reg;
	assign battery_fault = fault_reg;
	assign charge_status = stat_reg;
endmodule : ccr_regs

// [test/ccr_regs_asserts.sv]
`timescale 1ns/1ps
module ccr_regs_asserts
	import ccr_pkg::*;
#(
	parameter logic [2:0] REVISION = 3'h5
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input ccr_req_t req,
	input ccr_sense_t sense,
	input wire logic [7:0] rdata,
	input wire logic charger_reset,
	input wire logic converter_on,
	input wire logic short_clamp,
	input wire logic [16:0] reg_sense_uv,
	input wire logic [16:0] term_sense_uv,
	input wire logic [15:0] clamp_ua,
	input wire logic battery_fault,
	input wire logic [1:0] charge_status
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic rd_chg, wr_rst, rd_id, rd_bad;
	assign rd_chg = clk_en && req.rd && !req.wr && req.addr == CCR_OFS_CHARGE;
	assign wr_rst = clk_en && req.wr && req.addr == CCR_OFS_CHARGE
		&& req.wdata[7];
	assign rd_id = clk_en && req.rd && req.addr == CCR_OFS_IDENT;
	assign rd_bad = clk_en && req.rd && req.addr > 8'h04;
	rst_cmd_a: assert property (wr_rst |=> charger_reset)
		else $error("reset command not pulsed");
	no_cmd_a: assert property (!wr_rst |=> !charger_reset)
		else $error("reset pulse without command");
	bit7_one_a: assert property (rd_chg |=> rdata[7])
		else $error("reset bit read as zero");
	id_read_a: assert property (rd_id |=> rdata == {CCR_ID_UPPER, REVISION})
		else $error("identification read wrong");
	unmapped_a: assert property (rd_bad |=> rdata == 8'hff)
		else $error("unmapped read not ff");
	fast_uv_a: assert property (rd_chg |=>
		reg_sense_uv == 37400 + 6800 * rdata[6:4])
		else $error("fast sense voltage wrong");
	term_uv_a: assert property (rd_chg |=>
		term_sense_uv == 3400 + 3400 * rdata[2:0])
		else $error("termination sense voltage wrong");
	clamp_on_a: assert property (sense.below_short && clk_en |=>
		short_clamp && clamp_ua == 16'd10000)
		else $error("short clamp missing");
	fault_stop_a: assert property (battery_fault |->
		charge_status == 2'd3 && !converter_on)
		else $error("fault with converter on");
	refresh_go_a: assert property (charge_status == 2'd2 && clk_en
		&& sense.below_refresh && !charger_reset
		##1 clk_en && !charger_reset |=> charge_status == 2'd1)
		else $error("no recharge at refresh");
endmodule : ccr_regs_asserts
bind ccr_regs ccr_regs_asserts #(.REVISION(REVISION)) ccr_regs_asserts_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req),
	.sense(sense), .rdata(rdata), .charger_reset(charger_reset),
	.converter_on(converter_on), .short_clamp(short_clamp),
	.reg_sense_uv(reg_sense_uv), .term_sense_uv(term_sense_uv),
	.clamp_ua(clamp_ua), .battery_fault(battery_fault),
	.charge_status(charge_status));

// [test/ccr_host.sv]
`timescale 1ns/1ps
module ccr_host
	import ccr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] rdata,
	output ccr_req_t req
);
	initial req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk_sys);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys);
		req.rd <= 1'b0;
		@(negedge clk_sys);
		q = rdata;
	endtask : rd
endmodule : ccr_host

// [test/tb_ccr_regs.sv]
`timescale 1ns/1ps
module tb_ccr_regs
	import ccr_pkg::*;
;
	// Arbitrary revision value
	localparam logic [2:0] REV = 3'h2;
	localparam logic [7:0] ID_EXP = {CCR_ID_UPPER, REV};
	logic clk_sys = 0, rst_n = 0, clk_en = 1;
	ccr_req_t req;
	ccr_sense_t sense = '0;
	logic [7:0] rdata, q;
	logic charger_reset, converter_on, short_clamp, battery_fault;
	logic [16:0] reg_sense_uv, term_sense_uv;
	logic [15:0] clamp_ua;
	logic [1:0] charge_status;
	int n_errors = 0, n_checks = 0;
	// Address, write data, expected read
	logic [23:0] rows [7] = '{24'h040080, 24'h047fff, 24'h04d5d5,
		24'h01a5a5, {8'h03, 8'h33, ID_EXP}, 24'h0712ff, 24'h8000ff};
	always #10 clk_sys = ~clk_sys;
	ccr_regs #(.REVISION(REV), .SAFETY_CYCLES(20)) ccr_regs_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req),
		.sense(sense), .rdata(rdata), .charger_reset(charger_reset),
		.converter_on(converter_on), .short_clamp(short_clamp),
		.reg_sense_uv(reg_sense_uv), .term_sense_uv(term_sense_uv),
		.clamp_ua(clamp_ua), .battery_fault(battery_fault),
		.charge_status(charge_status));
	ccr_host ccr_host_i (.clk_sys(clk_sys), .rdata(rdata), .req(req));
	task automatic chk(input logic [16:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	initial begin
		cyc(10);
		rst_n = 1;
		ccr_host_i.rd(CCR_OFS_CHARGE, q);
		chk(q, 8'h89, "charge reset");
		ccr_host_i.rd(CCR_OFS_CONTROL, q);
		chk(q, 8'h30, "control reset");
		chk(reg_sense_uv, 37400, "fast reset");
		chk(term_sense_uv, 6800, "term reset");
		$display("test reset done");
		foreach (rows[i]) begin
			ccr_host_i.wr(rows[i][23:16], rows[i][15:8]);
			ccr_host_i.rd(rows[i][23:16], q);
			chk(q, rows[i][7:0], "readback");
		end
		$display("test table done");
		for (int c = 0; c < 8; c++) begin
			ccr_host_i.wr(CCR_OFS_CHARGE, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
			cyc(1);
			chk(reg_sense_uv, 17'(37400 + 6800 * c), "fast");
			chk(term_sense_uv, 17'(3400 + 3400 * (7 - c)), "term");
		end
		$display("test codes done");
		ccr_host_i.wr(CCR_OFS_CHARGE, 8'h80);
		chk(charger_reset, 1, "reset pulse");
		cyc(1);
		chk(charger_reset, 0, "pulse width");
		cyc(1);
		chk(charge_status, 0, "idle");
		ccr_host_i.wr(CCR_OFS_CHARGE, 8'h00);
		chk(charger_reset, 0, "zero write");
		cyc(30);
		chk(battery_fault, 1, "timer fault");
		chk(charge_status, 3, "fault status");
		chk(converter_on, 0, "fault stop");
		$display("test timer done");
		ccr_host_i.wr(CCR_OFS_CONTROL, 8'h30);
		sense.full = 1;
		sense.current_low = 1;
		ccr_host_i.wr(CCR_OFS_CHARGE, 8'h80);
		cyc(5);
		chk(charge_status, 1, "no termination");
		chk(converter_on, 1, "keeps running");
		ccr_host_i.wr(CCR_OFS_CONTROL, 8'h38);
		cyc(3);
		chk(charge_status, 2, "terminated");
		chk(converter_on, 0, "stopped");
		sense = '{1'b0, 1'b1, 1'b0, 1'b0};
		cyc(2);
		chk(charge_status, 1, "recharge");
		$display("test termination done");
		sense = '{1'b1, 1'b0, 1'b0, 1'b0};
		cyc(2);
		chk(short_clamp, 1, "clamp");
		chk(clamp_ua, 16'd10000, "clamp current");
		clk_en = 0;
		ccr_host_i.wr(CCR_OFS_CONTROL, 8'h00);
		clk_en = 1;
		ccr_host_i.rd(CCR_OFS_CONTROL, q);
		chk(q, 8'h38, "frozen");
		$display("test clamp done");
		stop_test();
	end
	// Nearly forty times the expected run
	initial begin
		#100us;
		n_errors++;
		stop_test();
	end
endmodule : tb_ccr_regs
